// ==== hdl/spfp_defs.vh ====
// Purpose: Shared constants of the supply-pulse fuse programmer
// Assumes: 20 MHz internal oscillator
// Notes:   Times in microseconds, cycle counts derived from them
`ifndef SPFP_DEFS_VH
`define SPFP_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Clock and pulse timing
`define SPFP_CLK_MHZ       20
`define SPFP_T_ACTIVE_US   20
`define SPFP_T_LOW_US      20
`define SPFP_T_BLOW_US     90
`define SPFP_CNT_W         12
// The times above at 20 MHz, sized to the counter so nothing is cut
`define SPFP_T_ACTIVE_CYC  12'h190
`define SPFP_T_LOW_CYC     12'h190
`define SPFP_T_BLOW_CYC    12'h708

////////////////////////////////////////////////////////////////////////////////
// Register keys and mode key
`define SPFP_KEY_TRIM_UP   4'h0
`define SPFP_KEY_TRIM_DOWN 4'h1
`define SPFP_KEY_FUSE_CHK  4'h7
`define SPFP_BLOW_KEY_MIDS 4'h9
`define SPFP_KEY_MAX       4'hf

////////////////////////////////////////////////////////////////////////////////
// Bit field codes and values
`define SPFP_FIELD_W       6
`define SPFP_CODE_FIRST    6'h01
`define SPFP_CODE_MAX      6'h3f
`define SPFP_CODE_CHK_LOW  6'h07
`define SPFP_CODE_CHK_HIGH 6'h0f
`define SPFP_LOCK_ADDR     6'h08
`define SPFP_ADDR_TOP_BIT  5
`define SPFP_TRY_RST       6'h00
`define SPFP_BURN_LOCK_BIT 6

`endif

// ==== hdl/spfp_pulse_meas.v ====
// Purpose: Synchronise the supply comparators and time each programming pulse
// Assumes: Mid comparator also trips at the high level
// Notes:   Mid and high events are one-cycle pulses issued when the supply returns low; bad is also held while the supply is below the low level
`timescale 1ns/1ns
`include "spfp_defs.vh"

module spfp_pulse_meas (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Raw comparator outputs
  input  wire       lvl_low_raw_i,
  input  wire       lvl_mid_raw_i,
  input  wire       lvl_high_raw_i,
  // Pulse events
  output reg        ev_mid_o,
  output reg        ev_high_o,
  output reg        ev_bad_o,
  output wire       high_long_o
);

  localparam [`SPFP_CNT_W-1:0] ACT_CYC  = `SPFP_T_ACTIVE_CYC;
  localparam [`SPFP_CNT_W-1:0] LOW_CYC  = `SPFP_T_LOW_CYC;
  localparam [`SPFP_CNT_W-1:0] BLOW_CYC = `SPFP_T_BLOW_CYC;
  localparam [`SPFP_CNT_W-1:0] CNT_SAT  = {`SPFP_CNT_W{1'b1}};

  reg  [2:0]             sync1_reg;
  reg  [2:0]             sync2_reg;
  reg                    in_pulse_reg;
  reg                    seen_high_reg;
  reg                    gap_ok_reg;
  reg  [`SPFP_CNT_W-1:0] width_reg;
  reg  [`SPFP_CNT_W-1:0] high_reg;
  reg  [`SPFP_CNT_W-1:0] gap_reg;
  wire                   supply_ok;
  wire                   active;
  wire                   at_high;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; only stage two is looked at
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {lvl_high_raw_i, lvl_mid_raw_i, lvl_low_raw_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign supply_ok = sync2_reg[0];
  assign active    = sync2_reg[1];
  assign at_high   = sync2_reg[2];

  // Live flag so the burn fires while the high level is still applied
  assign high_long_o = in_pulse_reg & at_high & (high_reg >= BLOW_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // Width, high time and gap counters, all saturating
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_pulse_reg  <= 1'b0;
      seen_high_reg <= 1'b0;
      gap_ok_reg    <= 1'b0;
      width_reg     <= {`SPFP_CNT_W{1'b0}};
      high_reg      <= {`SPFP_CNT_W{1'b0}};
      gap_reg       <= {`SPFP_CNT_W{1'b0}};
      ev_mid_o      <= 1'b0;
      ev_high_o     <= 1'b0;
      ev_bad_o      <= 1'b0;
    end else begin
      ev_mid_o  <= 1'b0;
      ev_high_o <= 1'b0;
      ev_bad_o  <= ~supply_ok;
      if (active && !in_pulse_reg) begin
        in_pulse_reg  <= 1'b1;
        gap_ok_reg    <= (gap_reg >= LOW_CYC);
        seen_high_reg <= at_high;
        width_reg     <= {{(`SPFP_CNT_W-1){1'b0}}, 1'b1};
        high_reg      <= {{(`SPFP_CNT_W-1){1'b0}}, at_high};
      end else if (active) begin
        seen_high_reg <= seen_high_reg | at_high;
        if (width_reg != CNT_SAT) begin
          width_reg <= width_reg + 1'b1;
        end
        if (at_high && high_reg != CNT_SAT) begin
          high_reg <= high_reg + 1'b1;
        end
      end else if (in_pulse_reg) begin
        in_pulse_reg <= 1'b0;
        gap_reg      <= {`SPFP_CNT_W{1'b0}};
        // A pulse that is too short or too close to the last one is noise
        if (!gap_ok_reg || width_reg < ACT_CYC || !supply_ok) begin
          ev_bad_o <= 1'b1;
        end else if (seen_high_reg) begin
          ev_high_o <= 1'b1;
        end else begin
          ev_mid_o <= 1'b1;
        end
      end else if (gap_reg != CNT_SAT) begin
        gap_reg <= gap_reg + 1'b1;
      end
    end
  end

endmodule

// ==== hdl/spfp_programmer.v ====
// Purpose: Decode supply pulses into register select, try and blow modes
// Assumes: rst_i is the power-on reset, raised whenever the supply is cycled
// Notes:   Fuses live outside; their state returns on fuse_trim_i and fuse_lock_i
`timescale 1ns/1ns
`include "spfp_defs.vh"

module spfp_programmer (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Supply level comparators
  input  wire       supply_level_low_i,
  input  wire       supply_level_mid_i,
  input  wire       supply_level_high_i,
  // Fuse array state
  input  wire [5:0] fuse_trim_i,
  input  wire       fuse_lock_i,
  input  wire       fuse_marginal_i,
  // Fuse burn control
  output reg        burn_en_o,
  output reg  [6:0] burn_sel_o,
  // Parameter and check outputs
  output reg  [5:0] operate_threshold_o,
  output reg        fuse_chk_low_o,
  output reg        fuse_chk_high_o,
  output reg        burn_current_extra_o,
  // Status
  output reg        locked_o,
  output wire       try_active_o,
  output wire       blow_active_o
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_KEY   = 5'h02;
  localparam [4:0] ST_TRY   = 5'h04;
  localparam [4:0] ST_BLOW  = 5'h08;
  localparam [4:0] ST_BURN  = 5'h10;

  reg  [4:0] state_reg;
  reg  [4:0] state_next;
  reg  [3:0] key_reg;
  reg  [3:0] key_next;
  reg  [5:0] code_reg;
  reg  [5:0] code_next;
  reg  [3:0] mids_reg;
  reg  [3:0] mids_next;
  reg  [5:0] addr_reg;
  reg  [5:0] addr_next;
  reg  [5:0] try_field_reg;
  reg  [5:0] try_field_next;
  reg        chk_low_reg;
  reg        chk_low_next;
  reg        chk_high_reg;
  reg        chk_high_next;
  reg        burn_en_next;
  reg  [6:0] burn_sel_next;
  reg        marg_s1_reg;
  reg        marg_s2_reg;
  wire       ev_mid;
  wire       ev_high;
  wire       ev_bad;
  wire       high_long;
  wire [5:0] code_inc;
  wire       lock_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse front end
  spfp_pulse_meas u_meas (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .lvl_low_raw_i  (supply_level_low_i),
    .lvl_mid_raw_i  (supply_level_mid_i),
    .lvl_high_raw_i (supply_level_high_i),
    .ev_mid_o       (ev_mid),
    .ev_high_o      (ev_high),
    .ev_bad_o       (ev_bad),
    .high_long_o    (high_long)
  );

  // Code saturates at the top rather than wrapping back to zero
  assign code_inc = (code_reg == `SPFP_CODE_MAX) ? code_reg : code_reg + 6'h01;
  assign lock_ok  = (key_reg == `SPFP_KEY_FUSE_CHK) && !fuse_lock_i;

  assign try_active_o  = state_reg[2];
  assign blow_active_o = state_reg[3] | state_reg[4];

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence decoder
  always @* begin
    state_next     = state_reg;
    key_next       = key_reg;
    code_next      = code_reg;
    mids_next      = mids_reg;
    addr_next      = addr_reg;
    try_field_next = try_field_reg;
    chk_low_next   = chk_low_reg;
    chk_high_next  = chk_high_reg;
    burn_en_next   = 1'b0;
    burn_sel_next  = burn_sel_reg_hold(burn_sel_o);
    case (state_reg)
      ST_IDLE: begin
        if (ev_high) begin
          state_next = ST_KEY;
          key_next   = 4'h0;
        end
      end
      ST_KEY: begin
        if (ev_bad) begin
          state_next = ST_IDLE;
        end else if (ev_mid) begin
          if (key_reg != `SPFP_KEY_MAX) begin
            key_next = key_reg + 4'h1;
          end
        end else if (ev_high) begin
          mids_next  = 4'h0;
          code_next  = `SPFP_CODE_FIRST;
          state_next = ST_TRY;
          // Once locked, only the fuse check register answers
          if (fuse_lock_i && key_reg != `SPFP_KEY_FUSE_CHK) begin
            state_next = ST_IDLE;
          end else if (key_reg == `SPFP_KEY_TRIM_UP) begin
            try_field_next = `SPFP_CODE_FIRST;
          end else if (key_reg == `SPFP_KEY_TRIM_DOWN) begin
            try_field_next = ~`SPFP_CODE_FIRST;
          end else if (key_reg != `SPFP_KEY_FUSE_CHK) begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_TRY: begin
        if (ev_bad) begin
          state_next = ST_IDLE;
        end else if (ev_mid) begin
          if (mids_reg != `SPFP_KEY_MAX) begin
            mids_next = mids_reg + 4'h1;
          end
          code_next = code_inc;
          // New value reaches the parameter right away for measurement
          if (key_reg == `SPFP_KEY_TRIM_UP) begin
            try_field_next = code_inc;
          end else if (key_reg == `SPFP_KEY_TRIM_DOWN) begin
            try_field_next = ~code_inc;
          end else begin
            chk_low_next  = (code_inc == `SPFP_CODE_CHK_LOW);
            chk_high_next = (code_inc == `SPFP_CODE_CHK_HIGH);
          end
        end else if (ev_high) begin
          chk_low_next  = 1'b0;
          chk_high_next = 1'b0;
          addr_next     = 6'h00;
          if (mids_reg == `SPFP_BLOW_KEY_MIDS) begin
            // Blow only on the trim-up key, or the lock before it is set
            if (key_reg == `SPFP_KEY_TRIM_UP || lock_ok) begin
              state_next = ST_BLOW;
            end else begin
              state_next = ST_IDLE;
            end
          end else begin
            // Any other high pulse opens the next register selection
            state_next = ST_KEY;
            key_next   = 4'h0;
          end
        end
      end
      ST_BLOW: begin
        if (ev_bad || ev_high) begin
          state_next = ST_IDLE;
        end else if (ev_mid) begin
          if (addr_reg == 6'h00) begin
            addr_next = 6'h01;
          end else if (addr_reg[`SPFP_ADDR_TOP_BIT]) begin
            state_next = ST_IDLE;
          end else begin
            addr_next = {addr_reg[4:0], 1'b0};
          end
        end else if (high_long && addr_reg != 6'h00) begin
          if (key_reg == `SPFP_KEY_TRIM_UP) begin
            state_next    = ST_BURN;
            burn_en_next  = 1'b1;
            burn_sel_next = {1'b0, addr_reg};
          end else if (addr_reg == `SPFP_LOCK_ADDR) begin
            state_next    = ST_BURN;
            burn_en_next  = 1'b1;
            burn_sel_next = 7'h40;
          end
        end
      end
      ST_BURN: begin
        // One fuse per sequence: the end of the blow pulse closes it
        if (ev_bad || ev_high || ev_mid) begin
          state_next = ST_IDLE;
        end else begin
          burn_en_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  function [6:0] burn_sel_reg_hold;
    input [6:0] cur;
    begin
      burn_sel_reg_hold = cur;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State registers; reset is the supply cycle and drops all try values
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ST_IDLE;
      key_reg       <= 4'h0;
      code_reg      <= 6'h00;
      mids_reg      <= 4'h0;
      addr_reg      <= 6'h00;
      try_field_reg <= `SPFP_TRY_RST;
      chk_low_reg   <= 1'b0;
      chk_high_reg  <= 1'b0;
      burn_en_o     <= 1'b0;
      burn_sel_o    <= 7'h00;
    end else begin
      state_reg     <= state_next;
      key_reg       <= key_next;
      code_reg      <= code_next;
      mids_reg      <= mids_next;
      addr_reg      <= addr_next;
      try_field_reg <= try_field_next;
      chk_low_reg   <= chk_low_next;
      chk_high_reg  <= chk_high_next;
      burn_en_o     <= burn_en_next;
      burn_sel_o    <= burn_sel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Marginal-fuse sense comes from an analog comparator
  always @(posedge clk_i) begin
    if (rst_i) begin
      marg_s1_reg <= 1'b0;
      marg_s2_reg <= 1'b0;
    end else begin
      marg_s1_reg <= fuse_marginal_i;
      marg_s2_reg <= marg_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      operate_threshold_o  <= 6'h00;
      fuse_chk_low_o       <= 1'b0;
      fuse_chk_high_o      <= 1'b0;
      burn_current_extra_o <= 1'b0;
      locked_o             <= 1'b0;
    end else begin
      // Blown bits are ORed in, so no try value can ever clear them
      operate_threshold_o  <= fuse_trim_i | try_field_reg;
      fuse_chk_low_o       <= chk_low_reg;
      fuse_chk_high_o      <= chk_high_reg;
      burn_current_extra_o <= (chk_low_reg | chk_high_reg) & marg_s2_reg;
      locked_o             <= fuse_lock_i;
    end
  end

endmodule

// ==== verif/spfp_supply_model.sv ====
// Purpose: Programming supply and fuse array seen from the device pins
// Assumes: Supply drops below the low level only when drop is called
// Notes:   Fuses blow when the burn request ends and are never cleared
`timescale 1ns/1ns

module spfp_supply_model #(
  parameter int ACT = 410,
  parameter int GAP = 410
) (
  // Clock
  input  wire        clk_i,
  // Burn request
  input  wire        burn_en_i,
  input  wire  [6:0] burn_sel_i,
  // Comparators and fuses
  output logic       lvl_low_o,
  output logic       lvl_mid_o,
  output logic       lvl_high_o,
  output logic [5:0] fuse_trim_o,
  output logic       fuse_lock_o
);
  logic burn_q;

  initial begin
    lvl_low_o = 1'b1;
    lvl_mid_o = 1'b0;
    lvl_high_o = 1'b0;
    fuse_trim_o = 6'h00;
    fuse_lock_o = 1'b0;
    burn_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mid comparator trips at the high level too; low gap follows each pulse
  task automatic pulse(input bit hi, input int w);
    @(posedge clk_i);
    lvl_mid_o <= 1'b1;
    lvl_high_o <= hi;
    repeat (w) @(posedge clk_i);
    lvl_mid_o <= 1'b0;
    lvl_high_o <= 1'b0;
    repeat (GAP) @(posedge clk_i);
  endtask

  // Brief dip below the low level, then a full gap
  task automatic drop(input int w);
    @(posedge clk_i);
    lvl_low_o <= 1'b0;
    repeat (w) @(posedge clk_i);
    lvl_low_o <= 1'b1;
    repeat (GAP) @(posedge clk_i);
  endtask

  task automatic mids(input int n);
    repeat (n) pulse(1'b0, ACT);
  endtask

  task automatic select(input int key);
    pulse(1'b1, ACT);
    mids(key);
    pulse(1'b1, ACT);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Burned fuses only ever accumulate, power cycling included
  always @(posedge clk_i) begin
    burn_q <= burn_en_i;
    if (burn_q && !burn_en_i) begin
      fuse_trim_o <= fuse_trim_o | burn_sel_i[5:0];
      fuse_lock_o <= fuse_lock_o | burn_sel_i[6];
    end
  end
endmodule

// ==== verif/spfp_programmer_chk.sv ====
// Purpose: Port-level checks of the fuse programmer
// Assumes: One clock domain, synchronous reset
// Notes:   Raw high-level time is counted here for the burn check
`timescale 1ns/1ns

module spfp_programmer_chk (
  input wire       clk_i,
  input wire       rst_i,
  input wire       supply_level_mid_i,
  input wire       supply_level_high_i,
  input wire [5:0] fuse_trim_i,
  input wire       fuse_lock_i,
  input wire       burn_en_o,
  input wire [6:0] burn_sel_o,
  input wire [5:0] operate_threshold_o,
  input wire       fuse_chk_low_o,
  input wire       fuse_chk_high_o,
  input wire       burn_current_extra_o,
  input wire       locked_o,
  input wire       try_active_o,
  input wire       blow_active_o
);
  int high_cnt = 0;

  always @(posedge clk_i) begin
    high_cnt <= supply_level_high_i ? ((high_cnt < 4000) ? high_cnt + 1 : high_cnt) : 0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_burn_start;
    $rose(burn_en_o);
  endsequence
  sequence s_blow_end;
    $fell(supply_level_mid_i) ##0 burn_en_o;
  endsequence

  burn_width_a: assert property (s_burn_start |-> high_cnt >= 1800)
    else $error("burn started before the high level was held long enough");
  burn_release_a: assert property (s_blow_end |-> ##[1:6] !burn_en_o)
    else $error("burn still requested after the pulse ended");
  one_fuse_a: assert property (burn_en_o |-> $onehot(burn_sel_o))
    else $error("burn select is not a single fuse");
  burn_in_blow_a: assert property (burn_en_o |-> blow_active_o)
    else $error("burn outside blow mode");
  mode_excl_a: assert property (!(try_active_o && blow_active_o))
    else $error("try and blow active together");
  fuse_keep_a: assert property (!$past(rst_i) && !$past(rst_i, 2) && $stable(fuse_trim_i)
    |-> (operate_threshold_o & fuse_trim_i) == fuse_trim_i) else $error("blown fuse not applied");
  lock_copy_a: assert property (!$past(rst_i) && fuse_lock_i |=> locked_o)
    else $error("lock fuse not reflected");
  locked_burn_a: assert property (locked_o |-> !burn_en_o)
    else $error("burn while locked");
  chk_excl_a: assert property (!(fuse_chk_low_o && fuse_chk_high_o))
    else $error("both fuse check thresholds active");
  extra_cause_a: assert property (burn_current_extra_o |-> fuse_chk_low_o || fuse_chk_high_o
    || $past(fuse_chk_low_o) || $past(fuse_chk_high_o)) else $error("extra current without check");
endmodule

// ==== verif/test_spfp_programmer.sv ====
// Purpose: Self-checking bench for the supply-pulse fuse programmer
// Assumes: 20 MHz clock, pulses and gaps slightly above 20 us
// Notes:   Reset stands for a supply power cycle
`timescale 1ns/1ns

module test_spfp_programmer;
  localparam int ACT = 410;
  localparam int GAP = 410;
  localparam int BURN = 1900;

  logic       clk_i;
  logic       rst_i;
  logic       fuse_marginal_i;
  wire        lvl_low, lvl_mid, lvl_high, burn_en_o, fuse_lock;
  wire        chk_low_o, chk_high_o, extra_o, locked_o, try_o, blow_o;
  wire  [5:0] fuse_trim, op_o;
  wire  [6:0] burn_sel_o;
  int         err_count = 0;
  int         checks = 0;
  int         burn_rises = 0;
  logic [6:0] burn_seen = 7'h00;
  logic       burn_q = 1'b0;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  spfp_programmer DUT (
    .clk_i(clk_i), .rst_i(rst_i), .supply_level_low_i(lvl_low), .supply_level_mid_i(lvl_mid),
    .supply_level_high_i(lvl_high), .fuse_trim_i(fuse_trim), .fuse_lock_i(fuse_lock),
    .fuse_marginal_i(fuse_marginal_i), .burn_en_o(burn_en_o), .burn_sel_o(burn_sel_o),
    .operate_threshold_o(op_o), .fuse_chk_low_o(chk_low_o), .fuse_chk_high_o(chk_high_o),
    .burn_current_extra_o(extra_o), .locked_o(locked_o), .try_active_o(try_o), .blow_active_o(blow_o));

  spfp_supply_model #(.ACT(ACT), .GAP(GAP)) m (
    .clk_i(clk_i), .burn_en_i(burn_en_o), .burn_sel_i(burn_sel_o), .lvl_low_o(lvl_low),
    .lvl_mid_o(lvl_mid), .lvl_high_o(lvl_high), .fuse_trim_o(fuse_trim), .fuse_lock_o(fuse_lock));

  always @(posedge clk_i) begin
    burn_q <= burn_en_o;
    if (burn_en_o && !burn_q) begin
      burn_rises <= burn_rises + 1;
      burn_seen <= burn_sel_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [6:0] seen, input logic [6:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic reset_dut();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (GAP) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_try_up();
    m.select(0);
    cmp({6'h00, try_o}, 7'h01, "try after key 0");
    cmp({1'b0, op_o}, 7'h01, "up first code");
    m.mids(2);
    cmp({1'b0, op_o}, 7'h03, "up code 3");
    m.drop(20);
    cmp({6'h00, try_o}, 7'h00, "supply loss ends try");
    cmp({1'b0, op_o}, 7'h03, "setting kept after supply loss");
  endtask

  task automatic t_try_down();
    m.select(1);
    cmp({1'b0, op_o}, 7'h3e, "down first code");
    m.mids(4);
    cmp({1'b0, op_o}, 7'h3a, "down code 5");
  endtask

  task automatic t_bad();
    m.select(0);
    m.mids(1);
    m.pulse(1'b0, 200);
    cmp({6'h00, try_o}, 7'h00, "short pulse leaves try");
    m.mids(1);
    cmp({1'b0, op_o}, 7'h02, "setting kept");
  endtask

  task automatic t_blow();
    reset_dut();
    m.select(0);
    m.mids(9);
    m.pulse(1'b1, ACT);
    cmp({6'h00, blow_o}, 7'h01, "blow key");
    m.mids(3);
    m.pulse(1'b1, BURN);
    cmp(burn_rises[6:0], 7'h01, "one burn");
    cmp(burn_seen, 7'h04, "third address");
    cmp({6'h00, blow_o}, 7'h00, "blow ends");
    reset_dut();
    cmp({1'b0, op_o}, 7'h04, "blown bit kept, try cleared");
  endtask

  task automatic t_lock();
    m.select(7);
    m.mids(9);
    m.pulse(1'b1, ACT);
    m.mids(4);
    m.pulse(1'b1, BURN);
    cmp(burn_seen, 7'h40, "lock fuse");
    reset_dut();
    cmp({6'h00, locked_o}, 7'h01, "locked");
    m.select(0);
    cmp({6'h00, try_o}, 7'h00, "trim refused");
  endtask

  task automatic t_check();
    @(posedge clk_i);
    fuse_marginal_i <= 1'b1;
    m.select(7);
    cmp({6'h00, try_o}, 7'h01, "check open when locked");
    m.mids(6);
    cmp({4'h0, chk_low_o, chk_high_o, extra_o}, 7'h05, "code 7");
    m.mids(8);
    cmp({4'h0, chk_low_o, chk_high_o, extra_o}, 7'h03, "code 15");
    @(posedge clk_i);
    fuse_marginal_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    cmp({6'h00, extra_o}, 7'h00, "no marginal fuse");
  endtask

  initial begin
    rst_i = 1'b1;
    fuse_marginal_i = 1'b0;
    reset_dut();
    t_try_up();
    t_try_down();
    t_bad();
    t_blow();
    t_lock();
    t_check();
    final_report();
  end

  // About 80 pulses of some 820 cycles plus two burns: roughly 71k cycles
  initial begin
    #(90000 * 50);
    err_count++;
    final_report();
  end
endmodule

bind spfp_programmer spfp_programmer_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .supply_level_mid_i(supply_level_mid_i),
  .supply_level_high_i(supply_level_high_i), .fuse_trim_i(fuse_trim_i), .fuse_lock_i(fuse_lock_i),
  .burn_en_o(burn_en_o), .burn_sel_o(burn_sel_o), .operate_threshold_o(operate_threshold_o),
  .fuse_chk_low_o(fuse_chk_low_o), .fuse_chk_high_o(fuse_chk_high_o),
  .burn_current_extra_o(burn_current_extra_o), .locked_o(locked_o), .try_active_o(try_active_o),
  .blow_active_o(blow_active_o));
